// file: core/fpe_regs.vh
// Purpose: Register map, field positions, reset values and timing counts of the frequency protection block.
// Assumes: APB with 32-bit data, byte addresses, each register one aligned word.
// Notes: Frequencies in 0.01 Hz, slopes in 0.01 Hz/s, magnitudes in 0.001 pu, delays in ms.
`ifndef FPE_REGS_VH
`define FPE_REGS_VH

// Global registers.
`define FPE_ADDR_STATUS 12'h000
`define FPE_ADDR_MASK 12'h004
`define FPE_ADDR_PICKUP 12'h008
`define FPE_ADDR_OPERATE 12'h00c
`define FPE_ADDR_TARGET 12'h010
`define FPE_ADDR_TGT_CLR 12'h014

// Element blocks: base + element * 16, four words each.
`define FPE_ELEM_PAGE 4'h1
`define FPE_BAND_PAGE 8'h20
`define FPE_WORD_CTRL 2'h0
`define FPE_WORD_LEVEL 2'h1
`define FPE_WORD_DELAY 2'h2
`define FPE_WORD_SUPV 2'h3

// Element counts and index ranges.
`define FPE_N_ELEM 14
`define FPE_N_LOW 6
`define FPE_N_HIGH 4
`define FPE_N_SLOPE 4
`define FPE_FIRST_HIGH 6
`define FPE_FIRST_SLOPE 10

// Control word fields.
`define FPE_CTRL_EN 0
`define FPE_CTRL_EVT 1
`define FPE_CTRL_TGT_LO 2
`define FPE_CTRL_TGT_HI 3
`define FPE_CTRL_SRC 4
`define FPE_CTRL_DIR_LO 5
`define FPE_CTRL_DIR_HI 6
`define FPE_TGT_SELF 2'h0
`define FPE_TGT_LATCH 2'h1
`define FPE_DIR_DEC 2'h0
`define FPE_DIR_INC 2'h1

// Reset values.
`define FPE_RST_CTRL 32'h00000000
`define FPE_RST_LOW_LEVEL 32'h0000173e
`define FPE_RST_HIGH_LEVEL 32'h000017a2
`define FPE_RST_SLOPE_LEVEL 32'h0000000a
`define FPE_RST_LOW_DELAY 32'h07d007d0
`define FPE_RST_SLOPE_DELAY 32'h00000000
`define FPE_RST_LOW_SUPV 32'h0000000a
`define FPE_RST_SLOPE_SUPV 32'h00c802bc
`define FPE_RST_BAND 32'h19641194
`define FPE_MIN_SCALE 5'd10

// Timing: delays count in steps of one millisecond.
`define FPE_CLK_PERIOD_NS 10
`define FPE_DELAY_STEP_NS 1000000

`endif

// file: core/fpe_sync.v
// Purpose: Three-stage synchroniser for asynchronous level inputs.
// Assumes: Inputs are slow levels from outside the clock domain.
// Notes: The output moves only when the second and third stages agree.
module fpe_sync #(
  parameter WIDTH = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_q
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // Shift the input through three flops and accept agreed values only.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_q <= (s2_q & ~(s2_q ^ s3_q)) | (sync_q & (s2_q ^ s3_q));
    end
  end
endmodule // fpe_sync

// file: core/fpe_delay.v
// Purpose: Pickup and reset delay timer of one protection element.
// Assumes: tick is a one-cycle pulse each millisecond.
// Notes: A zero delay acts in the cycle after the condition changes.
module fpe_delay (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire enable,
  input wire cond,
  input wire [15:0] pkp_ms,
  input wire [15:0] rst_ms,
  output reg operate_q
);
  reg [15:0] cnt_q;

  // Count whole milliseconds while the condition disagrees with the output.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      operate_q <= 1'b0;
    end else if (!enable) begin
      cnt_q <= 16'h0000;
      operate_q <= 1'b0;
    end else if (cond == operate_q) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q >= (operate_q ? rst_ms : pkp_ms)) begin
      operate_q <= cond;
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule // fpe_delay

// file: core/fpe_top.v
// Purpose: Frequency protection elements: six low, four high and four slope elements behind APB.
// Assumes: Measurement inputs come from logic on pclk; block inputs are asynchronous levels.
// Notes: Elements 0-5 are low frequency, 6-9 high frequency, 10-13 rate of change.
// Function
// R01: Six identical low-frequency elements, each with own settings and outputs.
// R02: Low-frequency signal is live phase voltage, else phase current, else none.
// R03: Low-frequency operation needs signal above minimum, 0.10 to 1.25 pu.
// R04: Low-frequency picks up when frequency falls below threshold, 20 to 65 Hz.
// R05: Operate after pickup delay, clear after reset delay, up to 65.535 s.
// R06: Target indication is self-resetting, latched until reset, or disabled.
// R07: Four high-frequency elements, each with own source and threshold.
// R08: Frequency from first live channel: VA, aux voltage, IA, ground current.
// R09: High-frequency picks up when frequency rises above its threshold.
// R10: Four rate-of-change elements with voltage, current and frequency supervision.
// R11: Direction selects negated slope, slope, or slope magnitude against threshold.
// R12: Slope threshold 0.10 to 15.00 Hz/s in 0.01 steps.
// R13: Slope operation needs positive-sequence voltage above supervision level.
// R14: Slope operation needs positive-sequence current above level; zero removes it.
// R15: Slope operation blocked while frequency is below band low limit.
// R16: Slope operation blocked while frequency is above band high limit.
// R17: Slope pickup and reset delays 0 to 65.535 s in ms steps.
// R18: Disabled or blocked element holds outputs low and resets its timers; a latched target stays set until cleared.
// R19: With events enabled, pickup, operate and dropout transitions are recorded.
`include "fpe_regs.vh"
module fpe_top #(
  parameter TICK_CYCLES = `FPE_DELAY_STEP_NS / `FPE_CLK_PERIOD_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [127:0] src_ch_freq,
  input wire [7:0] src_ch_present,
  input wire [31:0] src_vph_mag,
  input wire [31:0] src_iph_mag,
  input wire [31:0] src_v1_mag,
  input wire [31:0] src_i1_mag,
  input wire [31:0] src_dfdt,
  input wire [13:0] elem_block,
  output reg [13:0] elem_pickup,
  output reg [13:0] elem_operate,
  output reg [13:0] elem_target,
  output reg irq
);
  // Settings storage, one word per field of each element.
  reg [31:0] ctrl_q [0:13];
  reg [31:0] level_q [0:13];
  reg [31:0] delay_q [0:13];
  reg [31:0] supv_q [0:13];
  reg [31:0] band_q [0:3];

  // Event history, status, mask and the millisecond divider.
  reg [13:0] status_q;
  reg [13:0] mask_q;
  reg [13:0] pk_prev_q;
  reg [13:0] op_prev_q;
  reg [16:0] tick_cnt_q;
  reg tick_q;

  // Next values of the read mux, the status word and the targets.
  reg [31:0] rd_d;
  reg err_d;
  reg [13:0] status_d;
  reg [13:0] target_d;

  // Per-element results and the synchronised block inputs.
  wire [13:0] block_s;
  wire [13:0] pk_w;
  wire [13:0] op_w;
  wire [13:0] live_w;
  wire [13:0] evt_w;
  wire [13:0] tgt_clr_w;
  wire [16:0] src_freq [0:1];

  // Bus decode strobes and register indices.
  wire setup_w;
  wire access_w;
  wire wr_w;
  wire rd_status_w;
  wire elem_hit_w;
  wire band_hit_w;
  wire [3:0] eidx_w;
  wire [1:0] bidx_w;

  // Separate loop indices, so that no variable is written by two processes.
  integer k;
  integer j;
  genvar g;

  // Pick the first live channel of a source for its frequency.
  // A source with no live channel gives an invalid frequency, so nothing picks up on it.
  function [16:0] pick_freq;
    input [63:0] f;
    input [3:0] p;
    begin
      if (p[0]) begin
        pick_freq = {1'b1, f[15:0]};
      end else if (p[1]) begin
        pick_freq = {1'b1, f[31:16]};
      end else if (p[2]) begin
        pick_freq = {1'b1, f[47:32]};
      end else if (p[3]) begin
        pick_freq = {1'b1, f[63:48]};
      end else begin
        pick_freq = 17'h00000;
      end
    end
  endfunction

  // Frequency of each source with a valid flag on top.
  assign src_freq[0] = pick_freq(src_ch_freq[63:0], src_ch_present[3:0]); // [R08]
  assign src_freq[1] = pick_freq(src_ch_freq[127:64], src_ch_present[7:4]); // [R08]

  // Block inputs arrive from outside and are synchronised first.
  fpe_sync #(
    .WIDTH(14)
  ) u_block_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(elem_block),
    .sync_q(block_s)
  );

  // Millisecond enable for all delay timers.
  // The count restarts at reset, so the first tick comes a full period after release.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 17'h00000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES[16:0] - 17'h00001) begin
      tick_cnt_q <= 17'h00000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 17'h00001;
      tick_q <= 1'b0;
    end
  end

  // Per-element comparison logic and delay timers.
  generate
    for (g = 0; g < `FPE_N_ELEM; g = g + 1) begin : g_elem
      // One control bit picks the source that feeds this element.
      wire s = ctrl_q[g][`FPE_CTRL_SRC];
      wire [15:0] fq = src_freq[s][15:0];
      wire fvalid = src_freq[s][16];
      wire [15:0] thr = level_q[g][15:0];
      wire va_live = src_ch_present[s*4];
      wire ia_live = src_ch_present[s*4+2];
      // Magnitudes and slope of the chosen source.
      wire [15:0] vph = s ? src_vph_mag[31:16] : src_vph_mag[15:0];
      wire [15:0] iph = s ? src_iph_mag[31:16] : src_iph_mag[15:0];
      wire [15:0] v1 = s ? src_v1_mag[31:16] : src_v1_mag[15:0];
      wire [15:0] i1 = s ? src_i1_mag[31:16] : src_i1_mag[15:0];
      wire signed [16:0] df = s ? {src_dfdt[31], src_dfdt[31:16]} : {src_dfdt[15], src_dfdt[15:0]};
      wire signed [16:0] thr_s = {1'b0, thr};
      wire [1:0] dir = ctrl_q[g][`FPE_CTRL_DIR_HI:`FPE_CTRL_DIR_LO];
      // Low elements fall back to phase current when the phase voltage is dead.
      wire [15:0] sig = va_live ? vph : iph; // [R02]
      wire [20:0] min_sig = supv_q[g][15:0] * `FPE_MIN_SCALE;
      wire sig_ok = (va_live | ia_live) & ({5'h00, sig} > min_sig); // [R02] [R03]
      // Slope compare by direction; all three forms are strict.
      wire slope_hit = (dir == `FPE_DIR_DEC) ? (-df > thr_s) :
                       (dir == `FPE_DIR_INC) ? (df > thr_s) :
                       ((df < 17'sd0 ? -df : df) > thr_s); // [R11] [R12]
      // Positive-sequence supervision of the slope elements.
      wire v_ok = v1 > supv_q[g][15:0]; // [R13]
      wire i_ok = (supv_q[g][31:16] == 16'h0000) | (i1 > supv_q[g][31:16]); // [R14]
      wire cond;
      assign live_w[g] = ctrl_q[g][`FPE_CTRL_EN] & ~block_s[g]; // [R18]
      // The element index fixes the element type at elaboration.
      if (g < `FPE_FIRST_HIGH) begin : g_low
        assign cond = sig_ok & fvalid & (fq < thr); // [R01] [R04]
      end else if (g < `FPE_FIRST_SLOPE) begin : g_high
        assign cond = fvalid & (fq > thr); // [R07] [R09]
      end else begin : g_slope
        wire [31:0] bd = band_q[g-`FPE_FIRST_SLOPE];
        wire band_ok = (fq >= bd[15:0]) & (fq <= bd[31:16]); // [R15] [R16]
        assign cond = fvalid & slope_hit & v_ok & i_ok & band_ok; // [R10]
      end

      // Pickup is the raw condition, gated by enable and block.
      assign pk_w[g] = live_w[g] & cond; // [R18]
      fpe_delay u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_q),
        .enable(live_w[g]),
        .cond(cond),
        .pkp_ms(delay_q[g][15:0]),
        .rst_ms(delay_q[g][31:16]),
        .operate_q(op_w[g])
      ); // [R05] [R17] [R18]

      // Any edge of pickup or operate is an event when events are enabled.
      assign evt_w[g] = ctrl_q[g][`FPE_CTRL_EVT] & ((pk_w[g] ^ pk_prev_q[g]) | (op_w[g] ^ op_prev_q[g])); // [R19]
      assign tgt_clr_w[g] = wr_w & (paddr == `FPE_ADDR_TGT_CLR) & pwdata[g];
    end
  endgenerate

  // APB phase decode.
  // Element words 14 and 15 and every other hole answer with an error.
  assign setup_w = psel & ~penable;
  assign access_w = psel & penable & pready;
  assign wr_w = access_w & pwrite & ~pslverr;
  assign rd_status_w = access_w & ~pwrite & (paddr == `FPE_ADDR_STATUS);
  assign eidx_w = paddr[7:4];
  assign bidx_w = paddr[3:2];
  assign elem_hit_w = (paddr[11:8] == `FPE_ELEM_PAGE) & (eidx_w < 4'd14) & (paddr[1:0] == 2'h0);
  assign band_hit_w = (paddr[11:4] == `FPE_BAND_PAGE) & (paddr[1:0] == 2'h0);

  // Read mux and unmapped-address detection, sampled in the setup cycle.
  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    if (elem_hit_w) begin
      case (paddr[3:2])
        `FPE_WORD_CTRL: rd_d = ctrl_q[eidx_w];
        `FPE_WORD_LEVEL: rd_d = level_q[eidx_w];
        `FPE_WORD_DELAY: rd_d = delay_q[eidx_w];
        default: rd_d = supv_q[eidx_w];
      endcase
    end else if (band_hit_w) begin
      rd_d = band_q[bidx_w];
    end else begin
      case (paddr)
        `FPE_ADDR_STATUS: rd_d = {18'h00000, status_q};
        `FPE_ADDR_MASK: rd_d = {18'h00000, mask_q};
        `FPE_ADDR_PICKUP: rd_d = {18'h00000, elem_pickup};
        `FPE_ADDR_OPERATE: rd_d = {18'h00000, elem_operate};
        `FPE_ADDR_TARGET: rd_d = {18'h00000, elem_target};
        `FPE_ADDR_TGT_CLR: rd_d = 32'h00000000;
        default: err_d = 1'b1;
      endcase
    end
  end

  // Bus answer: ready in the first access cycle, data and error from the setup cycle.
  // A write lands at the access edge, and only when no error was flagged.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_w;
      if (setup_w) begin
        prdata <= pwrite ? 32'h00000000 : rd_d;
        pslverr <= err_d;
      end
    end
  end

  // Status clears only the bits that the read returned; a new event wins.
  // An event that lands between setup and access is therefore kept for the next read.
  always @* begin
    status_d = status_q;
    if (rd_status_w) begin
      status_d = status_d & ~prdata[13:0];
    end
    status_d = status_d | evt_w; // [R19]
  end

  // Target indication per element and mode; a new operate wins over a clear.
  always @* begin
    target_d = 14'h0000;
    for (j = 0; j < `FPE_N_ELEM; j = j + 1) begin
      case (ctrl_q[j][`FPE_CTRL_TGT_HI:`FPE_CTRL_TGT_LO])
        `FPE_TGT_SELF: target_d[j] = op_w[j]; // [R06]
        `FPE_TGT_LATCH: target_d[j] = op_w[j] | (elem_target[j] & ~tgt_clr_w[j]); // [R06]
        default: target_d[j] = 1'b0; // [R06]
      endcase
    end
  end

  // Element outputs, event history, status and interrupt.
  // History holds last cycle's pickup and operate, so both edges count as events.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elem_pickup <= 14'h0000;
      elem_operate <= 14'h0000;
      elem_target <= 14'h0000;
      pk_prev_q <= 14'h0000;
      op_prev_q <= 14'h0000;
      status_q <= 14'h0000;
      irq <= 1'b0;
    end else begin
      elem_pickup <= pk_w;
      elem_operate <= op_w;
      elem_target <= target_d;
      pk_prev_q <= pk_w;
      op_prev_q <= op_w;
      status_q <= status_d;
      irq <= |(status_d & mask_q);
    end
  end

  // Settings registers with per-type reset values.
  // High elements keep their supervision word as plain storage.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 14'h0000;
      for (k = 0; k < `FPE_N_ELEM; k = k + 1) begin
        ctrl_q[k] <= `FPE_RST_CTRL;
        if (k < `FPE_FIRST_HIGH) begin
          level_q[k] <= `FPE_RST_LOW_LEVEL;
          delay_q[k] <= `FPE_RST_LOW_DELAY;
          supv_q[k] <= `FPE_RST_LOW_SUPV;
        end else if (k < `FPE_FIRST_SLOPE) begin
          level_q[k] <= `FPE_RST_HIGH_LEVEL;
          delay_q[k] <= `FPE_RST_LOW_DELAY;
          supv_q[k] <= 32'h00000000;
        end else begin
          level_q[k] <= `FPE_RST_SLOPE_LEVEL;
          delay_q[k] <= `FPE_RST_SLOPE_DELAY;
          supv_q[k] <= `FPE_RST_SLOPE_SUPV;
        end
      end
      for (k = 0; k < `FPE_N_SLOPE; k = k + 1) begin
        band_q[k] <= `FPE_RST_BAND;
      end
    end else if (wr_w) begin
      if (elem_hit_w) begin
        case (paddr[3:2])
          // Only the seven defined control bits are kept; the rest read as zero.
          `FPE_WORD_CTRL: ctrl_q[eidx_w] <= {25'h0000000, pwdata[6:0]};
          `FPE_WORD_LEVEL: level_q[eidx_w] <= {16'h0000, pwdata[15:0]}; // [R04] [R12]
          `FPE_WORD_DELAY: delay_q[eidx_w] <= pwdata; // [R05] [R17]
          default: supv_q[eidx_w] <= pwdata; // [R03] [R13] [R14]
        endcase
      end else if (band_hit_w) begin
        band_q[bidx_w] <= pwdata; // [R15] [R16]
      end else if (paddr == `FPE_ADDR_MASK) begin
        mask_q <= pwdata[13:0];
      end
    end
  end
endmodule // fpe_top

// file: sim/fpe_top_props.sv
// Purpose: Port-level checks of the frequency protection block.
// Assumes: One clock pclk; presetn is asynchronous and active low.
// Notes: Bound to the top module at the foot of this file.
module fpe_top_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] src_ch_present,
  input wire [13:0] elem_block,
  input wire [13:0] elem_pickup,
  input wire [13:0] elem_operate,
  input wire [13:0] elem_target,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [83:0] blk_q;
  wire [13:0] held = blk_q[13:0] & blk_q[27:14] & blk_q[41:28] & blk_q[55:42] & blk_q[69:56] & blk_q[83:70];
  // Six past samples of the block inputs, so a block is judged only after the synchroniser.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) blk_q <= '0;
    else blk_q <= {blk_q[69:0], elem_block};
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer to setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_has_cause: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
  a_unmapped_refused: assert property (pready && paddr == 12'hffc |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_dead_source_quiet: assert property (src_ch_present == 8'h00 |=> elem_pickup == 14'h0)
    else $error("pickup with no live channel");
  a_block_holds_off: assert property (((elem_pickup | elem_operate) & held) == 14'h0)
    else $error("blocked element active");
  a_operate_after_pick: assert property ((elem_operate & ~$past(elem_operate) & ~$past(elem_pickup)) == 14'h0)
    else $error("operate without pickup");
  a_target_with_operate: assert property ((elem_target & ~$past(elem_target) & ~elem_operate) == 14'h0)
    else $error("target without operate");
  c_operate: cover property ($rose(elem_operate[0]));
  c_irq: cover property ($rose(irq));
  c_refused: cover property (pready && pslverr);
endmodule // fpe_top_props
bind fpe_top fpe_top_props i_fpe_top_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_ch_present(src_ch_present),
  .elem_block(elem_block), .elem_pickup(elem_pickup), .elem_operate(elem_operate), .elem_target(elem_target),
  .irq(irq));

// file: sim/fpe_meas.sv
// Purpose: Measurement front end model feeding frequencies and magnitudes.
// Assumes: Magnitudes and slope feed source 0 only; channels of both sources can be set.
// Notes: Setters use non-blocking updates, called just after a rising edge.
module fpe_meas (
  output logic [127:0] src_ch_freq = '0,
  output logic [7:0] src_ch_present = '0,
  output logic [31:0] src_vph_mag = '0,
  output logic [31:0] src_iph_mag = '0,
  output logic [31:0] src_v1_mag = '0,
  output logic [31:0] src_i1_mag = '0,
  output logic [31:0] src_dfdt = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sets frequency and liveness of channel c, 0 to 7; channels 4 to 7 belong to source 1.
  task automatic set_ch(input int c, input logic live, input logic [15:0] f);
    src_ch_freq[c*16 +: 16] <= f;
    src_ch_present[c] <= live;
  endtask
  // Sets the magnitudes and the slope of source 0.
  task automatic set_mag(input logic [15:0] vph, iph, v1, i1, df);
    src_vph_mag[15:0] <= vph;
    src_iph_mag[15:0] <= iph;
    src_v1_mag[15:0] <= v1;
    src_i1_mag[15:0] <= i1;
    src_dfdt[15:0] <= df;
  endtask
endmodule // fpe_meas

// file: sim/frequency_protection_elements_bench.sv
// Purpose: Self-checking bench of the frequency protection block.
// Assumes: Millisecond tick shortened to 10 clock cycles.
// Notes: Read data and error are taken at the edge where pready is sampled high.
module frequency_protection_elements_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [13:0] elem_block = 14'h0;
  wire [31:0] prdata, vph, iph, v1, i1, dfdt;
  wire pready, pslverr, irq;
  wire [127:0] fq;
  wire [7:0] live;
  wire [13:0] pick, oper, tgt;
  int mismatches = 0, checks = 0, n, e;
  logic [31:0] rdata = 32'h0;
  logic rerr = 1'b0;
  logic [11:0] ra [0:8] = '{12'h100, 12'h104, 12'h108, 12'h10c, 12'h164, 12'h1a4, 12'h1a8, 12'h1ac, 12'h200};
  logic [31:0] rv [0:8] = '{32'h0, 32'h173e, 32'h07d007d0, 32'ha, 32'h17a2, 32'ha, 32'h0, 32'h00c802bc, 32'h19641194};
  // Clock of 100 MHz.
  always #5 pclk = ~pclk;
  fpe_meas i_fpe_meas (.src_ch_freq(fq), .src_ch_present(live), .src_vph_mag(vph), .src_iph_mag(iph),
    .src_v1_mag(v1), .src_i1_mag(i1), .src_dfdt(dfdt));
  fpe_top #(.TICK_CYCLES(10)) i_fpe_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_ch_freq(fq), .src_ch_present(live), .src_vph_mag(vph), .src_iph_mag(iph), .src_v1_mag(v1),
    .src_i1_mag(i1), .src_dfdt(dfdt), .elem_block(elem_block), .elem_pickup(pick), .elem_operate(oper),
    .elem_target(tgt), .irq(irq));
  task automatic close_out;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  // One APB transfer, held until pready is sampled high.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
    if (pready !== 1'b1) begin
      mismatches++;
      close_out();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Lets outputs settle, then compares the low and high pickups.
  task automatic see(input logic [9:0] want);
    repeat (4) @(posedge pclk);
    chk(pick[9:0], want);
  endtask
  // Programs slope element 10 and the measurements, then compares its pickup.
  task automatic slope(input logic [1:0] dir, input logic [15:0] df, input logic want,
    input logic [15:0] v = 16'h03e8, i = 16'h012c, f = 16'h1770);
    xfer(1'b1, 12'h1a0, {25'h0, dir, 5'h03});
    i_fpe_meas.set_ch(0, 1'b1, f);
    i_fpe_meas.set_mag(16'h03e8, 16'h0032, v, i, df);
    repeat (4) @(posedge pclk);
    chk(pick[10], want);
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (e = 0; e < 9; e++) begin
      xfer(1'b0, ra[e], 32'h0);
      chk(rdata, rv[e]);
    end
    xfer(1'b0, 12'hffc, 32'h0);
    chk(rerr, 1'b1);
    chk(rdata, 32'h0);
    i_fpe_meas.set_ch(0, 1'b1, 16'h1770);
    i_fpe_meas.set_mag(16'h03e8, 16'h03e8, 16'h03e8, 16'h012c, 16'h0000);
    for (e = 0; e < 10; e++) begin
      xfer(1'b1, 12'h108 + 12'(e * 16), 32'h0);
      xfer(1'b1, 12'h100 + 12'(e * 16), 32'h3);
    end
    xfer(1'b1, 12'h004, 32'h3fff);
    i_fpe_meas.set_ch(0, 1'b1, 16'h170c);
    see(10'h03f);
    chk(oper[9:0], 10'h03f);
    chk(tgt[5:0], 6'h3f);
    chk(irq, 1'b1);
    xfer(1'b0, 12'h000, 32'h0);
    chk(rdata, 32'h3f);
    i_fpe_meas.set_ch(0, 1'b1, 16'h17d4);
    see(10'h3c0);
    chk(tgt[5:0], 6'h00);
    i_fpe_meas.set_ch(2, 1'b1, 16'h170c);
    see(10'h3c0);
    i_fpe_meas.set_ch(0, 1'b0, 16'h17d4);
    see(10'h03f);
    i_fpe_meas.set_mag(16'h03e8, 16'h0032, 16'h03e8, 16'h012c, 16'h0000);
    see(10'h000);
    xfer(1'b1, 12'h108, 32'h3);
    xfer(1'b1, 12'h100, 32'h5);
    i_fpe_meas.set_ch(0, 1'b1, 16'h170c);
    for (n = 0; n < 60 && oper[0] !== 1'b1; n++) @(posedge pclk);
    chk(n >= 19 && n <= 42, 1'b1);
    i_fpe_meas.set_ch(0, 1'b1, 16'h1770);
    repeat (4) @(posedge pclk);
    chk(oper[0], 1'b0);
    chk(tgt[0], 1'b1);
    xfer(1'b1, 12'h014, 32'h1);
    repeat (2) @(posedge pclk);
    chk(tgt[0], 1'b0);
    elem_block <= 14'h0001;
    i_fpe_meas.set_ch(0, 1'b1, 16'h170c);
    repeat (8) @(posedge pclk);
    chk(pick[0], 1'b0);
    elem_block <= 14'h0000;
    xfer(1'b1, 12'h004, 32'h0400);
    slope(2'h0, 16'hffce, 1'b1);
    slope(2'h0, 16'h0032, 1'b0);
    slope(2'h1, 16'h0032, 1'b1);
    slope(2'h1, 16'hffce, 1'b0);
    slope(2'h2, 16'hffce, 1'b1);
    slope(2'h1, 16'h000a, 1'b0);
    chk(irq, 1'b1);
    slope(2'h1, 16'h0032, 1'b0, 16'h02bc);
    slope(2'h1, 16'h0032, 1'b0, 16'h03e8, 16'h00c8);
    slope(2'h1, 16'h0032, 1'b0, 16'h03e8, 16'h012c, 16'h1193);
    slope(2'h1, 16'h0032, 1'b0, 16'h03e8, 16'h012c, 16'h1965);
    xfer(1'b1, 12'h1ac, 32'h000002bc);
    slope(2'h1, 16'h0032, 1'b1, 16'h03e8, 16'h0000);
    xfer(1'b1, 12'h160, 32'h1b);
    i_fpe_meas.set_ch(4, 1'b1, 16'h17d4);
    see(10'h040);
    chk(tgt[6], 1'b0);
    xfer(1'b1, 12'h160, 32'h1a);
    see(10'h000);
    i_fpe_meas.set_ch(2, 1'b0, 16'h170c);
    @(posedge pclk);
    i_fpe_meas.set_ch(4, 1'b0, 16'h170c);
    @(posedge pclk);
    i_fpe_meas.set_ch(0, 1'b0, 16'h170c);
    see(10'h000);
    chk(pick[13:10], 4'h0);
    xfer(1'b1, 12'h004, 32'h0000);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    close_out();
  end
endmodule // frequency_protection_elements_bench
